// *** shared/rsp_pkg.sv ***
// constants shared by both ends of the radio serial status/config link
// assumes a 200 MHz system clock on both ends
package rsp_pkg;
  // system clock and serial clock timing
  localparam int CLK_NS        = 5;
  localparam int SCLK_HALF_NS  = 80;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIV_W         = 5;
  // header byte layout
  localparam int HDR_RW_BIT    = 7;
  localparam int HDR_BURST_BIT = 6;
  localparam int ADDR_W        = 6;
  // configuration space
  localparam logic [5:0] CFG_LAST_ADDR = 6'h2E;
  localparam int         CFG_COUNT     = 47;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  // status byte layout
  localparam int STS_RDY_BIT   = 7;
  localparam int STS_STATE_LSB = 4;
  localparam logic [3:0] FIFO_SAT = 4'hF;
  // main state codes reported in status bits 6:4
  localparam logic [2:0] ST_IDLE        = 3'h0;
  localparam logic [2:0] ST_RX          = 3'h1;
  localparam logic [2:0] ST_TX          = 3'h2;
  localparam logic [2:0] ST_TX_SYNTH    = 3'h3;
  localparam logic [2:0] ST_CALIBRATE   = 3'h4;
  localparam logic [2:0] ST_SETTLING    = 3'h5;
  localparam logic [2:0] ST_RX_OVERRUN  = 3'h6;
  localparam logic [2:0] ST_TX_UNDERRUN = 3'h7;
  // host command port map
  localparam int         HREG_AW  = 5;
  localparam logic [4:0] HREG_CMD = 5'h00;
  localparam logic [4:0] HREG_STS = 5'h01;
  localparam logic [4:0] HREG_BUF = 5'h10;
  localparam int         HBUF_N   = 16;
endpackage : rsp_pkg

// *** shared/rsp_link_if.sv ***
// four-wire serial link between host and radio serial port
// assumes the data-out wire idles high when nobody drives it
`timescale 1ns/1ps
interface rsp_link_if;
  logic sclk;
  logic chip_select_n;
  logic si;
  logic so_out;
  logic so_oe;
  logic so;

  // resolved level of the shared data-out wire
  assign so = so_oe ? so_out : 1'b1;

  modport dev (input sclk, input chip_select_n, input si,
               output so_out, output so_oe);
  modport host (output sclk, output chip_select_n, output si, input so);
endinterface : rsp_link_if

// *** hdl/rsp_dev.sv ***
// radio serial slave port: status byte and configuration register access
// assumes link pins are asynchronous to clk; radio core inputs are on clk
// Behaviour
// [R1] data-out low only once crystal runs
// [R2] awake chip pulls data-out low immediately
// [R3] status byte shifted out during every header
// [R4] status bit 7 is active-low ready flag
// [R5] status bits 6:4 carry main state code
// [R6] transitional states may report idle code
// [R7] idle keeps only oscillator and core powered
// [R8] host changes frequency only in idle
// [R9] host flushes receive FIFO after overrun
// [R10] host acknowledges underrun with transmit flush
// [R11] bits 3:0 give rx count or tx free
// [R12] FIFO count saturates at fifteen
// [R13] config registers 0x00..0x2E read and write
// [R14] header write bit selects read or write
// [R15] writes return status for every byte
// [R16] reads return status only for header
// [R17] burst address counter steps every byte
// [R18] header: write bit, burst bit, address
// [R19] all bytes shift most significant first
// [R20] chip select high cancels the transfer
// [R21] host ends bursts by raising select
// [R22] sample on rising, change after falling
`timescale 1ns/1ps
module rsp_dev (
  input  wire logic       clk,
  input  wire logic       rstn,
  rsp_link_if.dev         link,
  input  wire logic       xtal_stable,
  input  wire logic [2:0] main_state,
  input  wire logic       transitional,
  input  wire logic [6:0] rx_count,
  input  wire logic [6:0] tx_free,
  input  wire logic [5:0] cfg_rd_addr,
  output logic      [7:0] cfg_rd_data,
  output logic            others_off,
  output logic            cfg_wr_pulse
);

  // saturating four-bit FIFO count
  function automatic logic [3:0] sat4(input logic [6:0] n);
    sat4 = (n > 7'(rsp_pkg::FIFO_SAT)) ? rsp_pkg::FIFO_SAT : n[3:0]; // [R12]
  endfunction : sat4

  // configuration address decode
  function automatic logic cfg_hit(input logic [5:0] a);
    cfg_hit = (a <= rsp_pkg::CFG_LAST_ADDR); // [R13]
  endfunction : cfg_hit

  logic       cs_s1_r, cs_s2_r;
  logic       sclk_s1_r, sclk_s2_r, sclk_d_r;
  logic       si_s1_r, si_s2_r;
  logic [2:0] bit_idx_r;
  logic [6:0] shift_r;
  logic       data_ph_r;
  logic       rw_r;
  logic       burst_r;
  logic [5:0] addr_r;
  logic [7:0] rd_byte_r;
  logic [7:0] cfg_r [0:rsp_pkg::CFG_COUNT-1];
  logic       so_r;
  logic       so_oe_r;
  logic       rise;
  logic       byte_done;
  logic [7:0] byte_in;
  logic [5:0] addr_nxt;
  logic [2:0] state_code;
  logic [7:0] status_byte;

  // two-flop synchronisers for the link pins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_d_r  <= 1'b0;
      si_s1_r   <= 1'b0;
      si_s2_r   <= 1'b0;
    end else begin
      cs_s1_r   <= link.chip_select_n;
      cs_s2_r   <= cs_s1_r;
      sclk_s1_r <= link.sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_d_r  <= sclk_s2_r;
      si_s1_r   <= link.si;
      si_s2_r   <= si_s1_r;
    end
  end

  // rising serial clock edge inside a selected frame
  assign rise      = sclk_s2_r & ~sclk_d_r & ~cs_s2_r; // [R22]
  assign byte_done = rise & (bit_idx_r == 3'h7);
  assign byte_in   = {shift_r, si_s2_r};                 // [R19]
  assign addr_nxt  = data_ph_r ? addr_r + 6'h01 : byte_in[5:0];

  // live status byte
  always_comb begin
    state_code = main_state; // [R5]
    if (transitional && (main_state == rsp_pkg::ST_CALIBRATE ||
                         main_state == rsp_pkg::ST_SETTLING)) begin
      state_code = rsp_pkg::ST_IDLE; // [R6]
    end
    status_byte = {~xtal_stable, state_code,
                   rw_r ? sat4(rx_count) : sat4(tx_free)}; // [R4] [R11]
  end

  // bit counter and input shifter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bit_idx_r <= 3'h0;
      shift_r   <= 7'h00;
    end else if (cs_s2_r) begin
      bit_idx_r <= 3'h0; // [R20]
    end else if (rise) begin
      bit_idx_r <= bit_idx_r + 3'h1;
      shift_r   <= byte_in[6:0]; // [R19]
    end
  end

  // header capture and phase tracking
  always_ff @(posedge clk) begin
    if (!rstn) begin
      data_ph_r <= 1'b0;
      rw_r      <= 1'b0;
      burst_r   <= 1'b0;
      addr_r    <= 6'h00;
    end else if (cs_s2_r) begin
      data_ph_r <= 1'b0; // [R20] [R21]
    end else if (rise && !data_ph_r && bit_idx_r == 3'h0) begin
      rw_r <= si_s2_r; // [R14] [R18]
    end else if (byte_done && !data_ph_r) begin
      burst_r   <= byte_in[rsp_pkg::HDR_BURST_BIT]; // [R18]
      addr_r    <= byte_in[5:0];                    // [R17]
      data_ph_r <= 1'b1;
    end else if (byte_done) begin
      if (burst_r) begin
        addr_r <= addr_r + 6'h01; // [R17]
      end else begin
        data_ph_r <= 1'b0;
      end
    end
  end

  // configuration register writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < rsp_pkg::CFG_COUNT; i++) begin
        cfg_r[i] <= rsp_pkg::CFG_RESET;
      end
      cfg_wr_pulse <= 1'b0;
    end else begin
      cfg_wr_pulse <= 1'b0;
      if (byte_done && data_ph_r && !rw_r && cfg_hit(addr_r)) begin
        cfg_r[addr_r] <= byte_in; // [R13] [R14]
        cfg_wr_pulse  <= 1'b1;
      end
    end
  end

  // read data staged for the next data byte
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_byte_r <= 8'h00;
    end else if (byte_done && (!data_ph_r || burst_r)) begin
      rd_byte_r <= cfg_hit(addr_nxt) ? cfg_r[addr_nxt] : 8'h00; // [R16]
    end
  end

  // serial output, changed only while the serial clock is low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      so_r    <= 1'b1;
      so_oe_r <= 1'b0;
    end else begin
      so_oe_r <= ~cs_s2_r; // [R2]
      if (cs_s2_r) begin
        so_r <= 1'b1;
      end else if (!sclk_s2_r) begin
        if (data_ph_r && rw_r) begin
          so_r <= rd_byte_r[~bit_idx_r]; // [R16] [R19] [R22]
        end else begin
          so_r <= status_byte[~bit_idx_r]; // [R1] [R3] [R15]
        end
      end
    end
  end

  assign link.so_out = so_r;
  assign link.so_oe  = so_oe_r;

  // user-side register view and idle power hint
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_rd_data <= 8'h00;
      others_off  <= 1'b1;
    end else begin
      cfg_rd_data <= cfg_hit(cfg_rd_addr) ? cfg_r[cfg_rd_addr] : 8'h00;
      others_off  <= (main_state == rsp_pkg::ST_IDLE); // [R7]
    end
  end

endmodule : rsp_dev

// *** hdl/rsp_host.sv ***
// serial master for the radio port, driven through a small command port
// assumes data-out is asynchronous to clk; software uses the command port
`timescale 1ns/1ps
module rsp_host (
  input  wire logic        clk,
  input  wire logic        rstn,
  rsp_link_if.host         link,
  input  wire logic [4:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata
);

  typedef enum {H_IDLE, H_WAIT_RDY, H_LOW, H_HIGH, H_GAP, H_HOLD} rsp_hst_t;

  rsp_hst_t   st_r;
  logic [7:0] buf_r [0:rsp_pkg::HBUF_N-1];
  logic [4:0] div_r;
  logic [2:0] bitn_r;
  logic [4:0] byten_r;
  logic [4:0] nbytes_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [7:0] status_r;
  logic       so_s1_r, so_s2_r;
  logic       sclk_r, cs_n_r, si_r;
  logic       half_done;
  logic [3:0] buf_idx;

  assign half_done = (div_r == 5'(rsp_pkg::SCLK_HALF_CYC - 1));
  assign buf_idx   = addr[3:0];

  // data-out synchroniser
  always_ff @(posedge clk) begin
    if (!rstn) begin
      so_s1_r <= 1'b1;
      so_s2_r <= 1'b1;
    end else begin
      so_s1_r <= link.so;
      so_s2_r <= so_s1_r;
    end
  end

  // half-period divider
  always_ff @(posedge clk) begin
    if (!rstn || st_r == H_IDLE || st_r == H_WAIT_RDY || half_done) begin
      div_r <= 5'h00;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end

  // transfer sequencer and buffer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r     <= H_IDLE;
      sclk_r   <= 1'b0;
      cs_n_r   <= 1'b1;
      si_r     <= 1'b0;
      bitn_r   <= 3'h0;
      byten_r  <= 5'h00;
      nbytes_r <= 5'h00;
      tx_r     <= 8'h00;
      rx_r     <= 8'h00;
      status_r <= 8'hFF;
      for (int i = 0; i < rsp_pkg::HBUF_N; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else begin
      case (st_r)
        H_IDLE: begin
          if (wr && addr == rsp_pkg::HREG_CMD) begin
            tx_r     <= wdata[7:0]; // [R18]
            nbytes_r <= {1'b0, wdata[11:8]};
            byten_r  <= 5'h00;
            bitn_r   <= 3'h0;
            cs_n_r   <= 1'b0;
            st_r     <= H_WAIT_RDY;
          end else if (wr && addr[4]) begin
            buf_r[buf_idx] <= wdata[7:0];
          end
        end
        H_WAIT_RDY: begin
          if (!so_s2_r) begin
            si_r <= tx_r[7]; // [R4] [R19]
            st_r <= H_LOW;
          end
        end
        H_LOW: begin
          if (half_done) begin
            sclk_r <= 1'b1;
            rx_r   <= {rx_r[6:0], so_s2_r}; // [R22]
            st_r   <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (half_done) begin
            sclk_r <= 1'b0;
            bitn_r <= bitn_r + 3'h1;
            if (bitn_r == 3'h7) begin
              if (byten_r == 5'h00) begin
                status_r <= rx_r;
              end else begin
                buf_r[4'(byten_r - 5'h01)] <= rx_r;
              end
              if (byten_r == nbytes_r) begin
                st_r <= H_GAP;
              end else begin
                tx_r    <= buf_r[4'(byten_r)];
                si_r    <= buf_r[4'(byten_r)][7]; // [R19]
                byten_r <= byten_r + 5'h01;
                st_r    <= H_LOW;
              end
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              si_r <= tx_r[6]; // [R22]
              st_r <= H_LOW;
            end
          end
        end
        H_GAP: begin
          if (half_done) begin
            cs_n_r <= 1'b1; // [R21]
            st_r   <= H_HOLD;
          end
        end
        H_HOLD: begin
          if (half_done) begin
            st_r <= H_IDLE;
          end
        end
        default: begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  assign link.sclk          = sclk_r;
  assign link.chip_select_n = cs_n_r;
  assign link.si            = si_r;

  // command port read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rstn || !rd) begin
      rdata <= 16'h0000;
    end else if (addr == rsp_pkg::HREG_STS) begin
      rdata <= {status_r, 4'h0,
        status_r[6:4] == rsp_pkg::ST_TX_UNDERRUN, // [R10]
        status_r[6:4] == rsp_pkg::ST_RX_OVERRUN,  // [R9]
        status_r[6:4] == rsp_pkg::ST_IDLE,        // [R8]
        st_r != H_IDLE};
    end else if (addr[4]) begin
      rdata <= {8'h00, buf_r[buf_idx]};
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule : rsp_host

// *** tb/rsp_props.sv ***
// link checker between the host and device ends
// assumes link signals settle on the shared system clock
`timescale 1ns/1ps
module rsp_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic so
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic       sclk_r;
  logic [7:0] rises_r;
  // count serial clock rises inside a frame
  always_ff @(posedge clk) begin
    sclk_r  <= sclk;
    if (!rstn || chip_select_n) rises_r <= 8'h00;
    else if (sclk && !sclk_r) rises_r <= rises_r + 8'h01;
  end
  AST_OE_ON: assert property ($fell(chip_select_n) |-> ##[1:5] so_oe)
    else $error("data-out not driven after select");
  AST_OE_OFF: assert property (
    $rose(chip_select_n) |-> ##[1:5] !so_oe)
    else $error("data-out still driven after deselect");
  AST_FIRST: assert property ($rose(sclk) && rises_r == 8'h00 |-> !so)
    else $error("ready flag high at first clock rise");
  AST_SO_HOLD: assert property (
    sclk && $past(sclk) && so_oe |-> $stable(so_out))
    else $error("data-out moved while clock high");
  AST_SI_HOLD: assert property (sclk && $past(sclk) |-> $stable(si))
    else $error("data-in moved while clock high");
  AST_IDLE: assert property (chip_select_n |-> !sclk)
    else $error("clock high outside a frame");
  AST_HIGH: assert property ($rose(sclk) |-> sclk [*8])
    else $error("clock high phase too short");
  AST_SETUP: assert property ($fell(chip_select_n) |-> !sclk [*8])
    else $error("clock rose too soon after select");
  // frames seen
  cover property ($fell(chip_select_n));
  cover property (rises_r == 8'h20);
  cover property ($rose(chip_select_n));
endmodule : rsp_props

// *** tb/tb_top.sv ***
// self-checking bench for the host and device ends of the serial link
// assumes both ends share one 200 MHz clock and one reset
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] d;
    logic [2:0] st;
    logic       tr;
    logic [6:0] rx;
    logic [6:0] tx;
  } rsp_row_t;
  logic        clk;
  logic        rstn;
  logic        xtal;
  logic        tr;
  logic        wr;
  logic        rd;
  logic [2:0]  st;
  logic [6:0]  rx;
  logic [6:0]  tx;
  logic [5:0]  cra;
  logic [7:0]  crd;
  logic        off;
  logic        wp;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] s;
  logic [15:0] sh;
  int          fail_count;
  int          comparisons;
  int          cycles;
  int          wpn;
  logic [7:0]  e;
  rsp_row_t    r;
  logic [7:0]  bv [3] = '{8'hA1, 8'hB2, 8'hC3};
  rsp_row_t    rows [8] = '{
    '{6'h00, 8'h5A, 3'h0, 1'h0, 7'h00, 7'h10},
    '{6'h2E, 8'hA5, 3'h1, 1'h0, 7'h0F, 7'h0E},
    '{6'h15, 8'h3C, 3'h2, 1'h0, 7'h7F, 7'h01},
    '{6'h01, 8'hFF, 3'h3, 1'h0, 7'h10, 7'h0F},
    '{6'h2A, 8'h81, 3'h4, 1'h1, 7'h03, 7'h7F},
    '{6'h07, 8'h00, 3'h5, 1'h0, 7'h0E, 7'h00},
    '{6'h10, 8'h7E, 3'h6, 1'h0, 7'h01, 7'h02},
    '{6'h2D, 8'hC3, 3'h7, 1'h1, 7'h0C, 7'h0D}};
  rsp_link_if link ();
  rsp_dev i_rsp_dev (.clk(clk), .rstn(rstn), .link(link), .xtal_stable(xtal),
    .main_state(st), .transitional(tr), .rx_count(rx), .tx_free(tx),
    .cfg_rd_addr(cra), .cfg_rd_data(crd), .others_off(off),
    .cfg_wr_pulse(wp));
  rsp_host i_rsp_host (.clk(clk), .rstn(rstn), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  rsp_props i_rsp_props (.clk(clk), .rstn(rstn), .sclk(link.sclk),
    .chip_select_n(link.chip_select_n), .si(link.si),
    .so_out(link.so_out), .so_oe(link.so_oe), .so(link.so));
  // clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // bits seen on data-in at clock rises
  always @(posedge link.sclk) begin
    if (!link.chip_select_n) sh <= {sh[14:0], link.si};
  end
  // config write pulses seen
  always @(posedge clk) begin
    if (wp === 1'h1) wpn++;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      complete_run();
    end
  end
  function automatic logic [7:0] es(input rsp_row_t q, input logic rw);
    logic [6:0] c;
    c = rw ? q.rx : q.tx;
    es = {1'h0, (q.tr && q.st[2:1] == 2'h2) ? 3'h0 : q.st,
          (c > 7'h0F) ? 4'hF : c[3:0]};
  endfunction : es
  task chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task bwr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : bwr
  task brd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(posedge clk);
    d = rdata;
  endtask : brd
  task idle();
    s = 16'h0001;
    for (int i = 0; i < 4000 && s[0] !== 1'h0; i++)
      brd(rsp_pkg::HREG_STS, s);
    chk(s[0], 1'h0);
  endtask : idle
  task run(input logic [7:0] h, input logic [3:0] n);
    bwr(rsp_pkg::HREG_CMD, {4'h0, n, h});
    idle();
  endtask : run
  task complete_run();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    {rstn, wr, rd, tr, st, rx, tx, cra, addr, wdata} = '0;
    xtal = 1'h1;
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      r = rows[i];
      st <= r.st;
      tr <= r.tr;
      rx <= r.rx;
      tx <= r.tx;
      bwr(rsp_pkg::HREG_BUF, {8'h00, r.d});
      run({2'h0, r.a}, 4'h1);
      chk(s[15:8], es(r, 1'h0));
      e = es(r, 1'h0);
      chk(s[3:0], {e[6:4] == 3'h7, e[6:4] == 3'h6,
                   e[6:4] == 3'h0, 1'h0});
      chk(16'(wpn), 16'(i + 1));
      chk(sh, {2'h0, r.a, r.d});
      brd(rsp_pkg::HREG_BUF, s);
      chk(s[7:0], es(r, 1'h0));
      run({2'h2, r.a}, 4'h1);
      chk(s[15:8], es(r, 1'h1));
      brd(rsp_pkg::HREG_BUF, s);
      chk(s[7:0], r.d);
      cra <= r.a;
      repeat (2) @(posedge clk);
      chk(crd, r.d);
      chk(off, r.st == 3'h0);
      $display("row %0d done", i);
    end
    // burst across the top of the register space
    for (int k = 0; k < 3; k++) bwr(rsp_pkg::HREG_BUF + 5'(k), {8'h00, bv[k]});
    run(8'h6D, 4'h3);
    run(8'hED, 4'h3);
    for (int k = 0; k < 3; k++) begin
      brd(rsp_pkg::HREG_BUF + 5'(k), s);
      chk(s[7:0], (k < 2) ? bv[k] : 8'h00);
    end
    chk(16'(wpn), 16'h000A);
    brd(5'h05, s);
    chk(s, 16'h0000);
    $display("burst done");
    // frame held off until the crystal runs
    xtal <= 1'h0;
    bwr(rsp_pkg::HREG_CMD, 16'h0180);
    repeat (40) @(posedge clk);
    chk(link.so, 1'h1);
    chk(link.sclk, 1'h0);
    xtal <= 1'h1;
    idle();
    chk(s[15], 1'h0);
    $display("crystal wait done");
    // reset in mid-run
    rstn <= 1'h0;
    repeat (3) @(posedge clk);
    chk(off, 1'h1);
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    cra  <= 6'h15;
    repeat (4) @(posedge clk);
    chk(crd, 8'h00);
    brd(rsp_pkg::HREG_STS, s);
    chk(s[15:8], 8'hFF);
    $display("reset done");
    // header-only frame; select high must drop the data phase
    run(8'h03, 4'h0);
    bwr(rsp_pkg::HREG_BUF, 16'h0099);
    run(8'h04, 4'h1);
    cra <= 6'h03;
    repeat (2) @(posedge clk);
    chk(crd, 8'h00);
    cra <= 6'h04;
    repeat (2) @(posedge clk);
    chk(crd, 8'h99);
    $display("cut frame done");
    complete_run();
  end
endmodule : tb_top
